// file: design/sec_ctl_defines.svh
// Register offsets, field positions and reset values of the security control block.
// Assumes inclusion by bare name; definitions only.
`ifndef SEC_CTL_DEFINES_SVH
`define SEC_CTL_DEFINES_SVH
// ************************************
// Register byte offsets
// ************************************
`define OFF_ID 8'h00
`define OFF_NS_CTRL 8'h04
`define OFF_NS_BYP 8'h08
`define OFF_S_CTRL 8'h0C
`define OFF_S_BYP 8'h10
`define OFF_STAT 8'h14
// ************************************
// Field positions
// ************************************
`define CB_EN 0
`define CB_CMDQ 1
`define CB_EVTQ 2
`define CB_PRIQ 3
`define BB_ABORT 0
`define BB_NSOVR 1
`define BB_NSVAL 2
`define IB_SEC 0
`define IB_SECURE_EL2_SUPPORTED 1
`define CFG_S1BIT 0
`define CFG_S2BIT 1
`define STAT_S_LSB 8
// ************************************
// Constant values
// ************************************
`define CFG_S2ONLY 3'h6
`define VMID_ZERO 16'h0000
`define CTRL_RST 4'h0
`define ABORT_RST 1'h0
`define WORD_ZERO 32'h0000_0000
`define ST_NS 1'h0
`define ST_S 1'h1
`endif

// file: design/sec_ctl_pkg.sv
// Types shared by the security control block, its checker, client model and bench.
// Assumes the defines header is not needed here; types only.
package sec_ctl_pkg;
  // Incoming transaction with its stream table and descriptor fields
  typedef struct packed {
    logic stream_security_identifier;
    logic ns_in;
    logic [2:0] cfg;
    logic substream_skip_select;
    logic [1:0] bypass_security_select;
    logic stage2_secure_walk_attr;
    logic stage2_secure_output_attr;
    logic stage2_nonsec_walk_attr;
    logic stage2_nonsec_output_attr;
    logic stage2_long_format_flag;
    logic [15:0] stage2_vm_tag;
    logic s1_out_ns;
    logic el2_walk;
    logic [1:0] cd_bypass_security_select;
    logic ttb_sel;
  } req_t;
  // Decision for one transaction
  typedef struct packed {
    logic abort;
    logic bypass;
    logic translate;
    logic final_ns;
    logic walk_ns;
    logic use_nonsec_ipa_base;
    logic [15:0] vm_tag;
    logic not_global_bit;
    logic stream_table_read;
    logic cd_fetch_ns;
    logic init_walk_ns;
  } rsp_t;
  // Per Security state service permissions
  typedef struct packed {
    logic cmd_ok;
    logic evt_new_ok;
    logic evt_drain_ok;
    logic pri_ok;
    logic xlat_op_ok;
    logic strtab_ok;
  } svc_t;
  typedef enum logic [0:0] {
    APB_IDLE = 1'b0,
    APB_ACC = 1'b1
  } apb_st_t;
endpackage : sec_ctl_pkg

// file: design/s2_space_resolve.sv
// Stage 2 IPA space selection and output security for a Secure stream.
// Assumes purely combinational use inside the control block.
`timescale 1ns/1ns
module s2_space_resolve (
  input wire logic ns_in, // Stage 1 output NS
  input wire logic sw_in, // Secure space walk attribute
  input wire logic sa_in, // Secure space output attribute
  input wire logic nsw_in, // Non-secure space walk attribute
  input wire logic nsa_in, // Non-secure space output attribute
  output logic walk_ns_out, // Table access NS
  output logic final_ns_out, // Final NS
  output logic nonsec_base_out // Non-secure IPA base selected
);
  // Space choice follows the stage 1 output NS
  always_comb begin
    nonsec_base_out = ns_in;
    if (!ns_in) begin
      walk_ns_out = sw_in;
      final_ns_out = sw_in ? 1'b1 : sa_in;
    end else begin
      walk_ns_out = nsw_in;
      // Either walk bit set forces Non-secure output
      final_ns_out = (!sw_in && !nsw_in) ? nsa_in : 1'b1;
    end
  end
endmodule : s2_space_resolve

// file: design/secure_stage2_and_enable_ctl.sv
// Per Security state enable, bypass and Secure stage 2 attribute control.
// Assumes an APB master on CLK_IN and a transaction source on the same clock.
`timescale 1ns/1ns
`include "sec_ctl_defines.svh"
// How it works
// - Secure entry config bit 1 enables stage 2
// - ID flags report security and EL2 support
// - Secure EL2 only with both stages present
// - NS 0 input: Secure base, secure walk
// - NS 1 input: Non-secure base, nonsecure walk
// - Non-secure streams always walk and output NS
// - Secure stage 1 fetches descriptor via Secure IPA
// - Stage-2-only takes NS from entry field
// - EL2 initial walk security from descriptor bit
// - No stage 2: IPA space maps to PA
// - Secure TLB tag is VMID or zero
// - Non-secure IPA entries are non-global
// - Reset disabled, bypass or abort per state
// - Disabled: abort or bypass with attributes
// - Disabled: never read the stream table
// - Disabled: deny pages, no translation ops
// - Disabled: registers and commands still work
// - Disabled: no new events, drain old ones
// - Enabled: follow entry, each state separately
// - No Secure interface: output NS always 1
// - Identifier 1 Secure, 0 Non-secure
module secure_stage2_and_enable_ctl #(
  parameter logic SECURE_INTERFACE_PRESENT = 1'b1,
  parameter logic SECURE_EL2_SUPPORTED_IMPL = 1'b1,
  parameter logic S1_IMPL = 1'b1,
  parameter logic S2_IMPL = 1'b1,
  parameter logic NS_ABORT_RST = `ABORT_RST,
  parameter logic S_ABORT_RST = `ABORT_RST
) (
  input wire logic CLK_IN, // Clock, 10 MHz
  input wire logic RST_B_IN, // Async reset, active low
  input wire logic CE_IN, // Clock enable, freezes state when low
  input wire logic PSEL_IN, // APB select
  input wire logic PENABLE_IN, // APB enable
  input wire logic PWRITE_IN, // APB direction
  input wire logic [7:0] PADDR_IN, // APB byte address
  input wire logic [31:0] PWDATA_IN, // APB write data
  output logic [31:0] PRDATA_OUT, // APB read data
  output logic PREADY_OUT, // APB ready
  output logic PSLVERR_OUT, // APB error
  input wire logic REQ_VALID_IN, // Transaction offered
  input wire sec_ctl_pkg::req_t REQ_IN, // Transaction fields
  output logic RSP_VALID_OUT, // Decision valid, one cycle
  output sec_ctl_pkg::rsp_t RSP_OUT, // Decision
  output sec_ctl_pkg::svc_t NS_SVC_OUT, // Non-secure services
  output sec_ctl_pkg::svc_t S_SVC_OUT // Secure services
);
  import sec_ctl_pkg::*;

  // ************************************
  // Options and decode helpers
  // ************************************
  // Secure EL2 only counts when both stages exist
  localparam logic SECURE_EL2_SUPPORTED_EFF = SECURE_INTERFACE_PRESENT & SECURE_EL2_SUPPORTED_IMPL & S1_IMPL & S2_IMPL;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Secure registers vanish without a Secure interface
  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, `OFF_ID) || hit(a, `OFF_NS_CTRL) || hit(a, `OFF_NS_BYP)
      || hit(a, `OFF_STAT)
      || (SECURE_INTERFACE_PRESENT && (hit(a, `OFF_S_CTRL) || hit(a, `OFF_S_BYP)));
  endfunction : mapped

  // ************************************
  // Register state
  // ************************************
  // Index 0 holds the Non-secure copy, index 1 the Secure copy
  logic [3:0] ctrl_ff [2];
  logic [3:0] nxt_ctrl [2];
  logic [2:0] byp_ff [2];
  logic [2:0] nxt_byp [2];
  apb_st_t apb_ff;
  apb_st_t nxt_apb;
  logic [31:0] nxt_prdata;
  logic nxt_pready;
  logic nxt_pslverr;
  logic wr_go;
  logic [31:0] id_word;
  logic [31:0] stat_word;
  svc_t svc [2];

  // Identification word
  always_comb begin
    // Reads as zero above the two flags
    id_word = `WORD_ZERO;
    id_word[`IB_SEC] = SECURE_INTERFACE_PRESENT;
    id_word[`IB_SECURE_EL2_SUPPORTED] = SECURE_EL2_SUPPORTED_EFF;
  end

  // Service permissions per state, recomputed from control state
  // Event drain needs no enable: buffered events may still go out
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      svc[s].cmd_ok = ctrl_ff[s][`CB_CMDQ];
      svc[s].evt_drain_ok = ctrl_ff[s][`CB_EVTQ];
      svc[s].evt_new_ok = ctrl_ff[s][`CB_EN] & ctrl_ff[s][`CB_EVTQ];
      svc[s].pri_ok = ctrl_ff[s][`CB_EN] & ctrl_ff[s][`CB_PRIQ];
      svc[s].xlat_op_ok = ctrl_ff[s][`CB_EN];
      svc[s].strtab_ok = ctrl_ff[s][`CB_EN];
    end
  end

  // Status word mirrors the service bits of both states
  always_comb begin
    stat_word = `WORD_ZERO;
    stat_word[5:0] = svc[`ST_NS];
    stat_word[`STAT_S_LSB +: 6] = svc[`ST_S];
  end

  // ************************************
  // APB slave
  // ************************************
  // Setup cycle loads read data; access phase completes at once
  // Zero wait states keep the slave simple; a slow master only costs idle cycles
  // Read data is picked in setup so the access cycle presents it from a flop
  always_comb begin
    nxt_apb = apb_ff;
    nxt_prdata = PRDATA_OUT;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    case (apb_ff)
      APB_IDLE: begin
        if (PSEL_IN && !PENABLE_IN) begin
          nxt_apb = APB_ACC;
          nxt_pready = 1'b1;
          nxt_pslverr = !mapped(PADDR_IN);
          nxt_prdata = `WORD_ZERO;
          if (!PWRITE_IN) begin
            // Registers stay readable whatever the enables
            if (hit(PADDR_IN, `OFF_ID)) nxt_prdata = id_word;
            if (hit(PADDR_IN, `OFF_NS_CTRL)) nxt_prdata[3:0] = ctrl_ff[`ST_NS];
            if (hit(PADDR_IN, `OFF_NS_BYP)) nxt_prdata[2:0] = byp_ff[`ST_NS];
            if (SECURE_INTERFACE_PRESENT && hit(PADDR_IN, `OFF_S_CTRL)) begin
              nxt_prdata[3:0] = ctrl_ff[`ST_S];
            end
            if (SECURE_INTERFACE_PRESENT && hit(PADDR_IN, `OFF_S_BYP)) begin
              nxt_prdata[2:0] = byp_ff[`ST_S];
            end
            if (hit(PADDR_IN, `OFF_STAT)) nxt_prdata = stat_word;
          end
        end
      end
      APB_ACC: begin
        // Transfer ends at this edge; hold ready low afterwards
        nxt_apb = APB_IDLE;
      end
      default: begin
        nxt_apb = APB_IDLE;
      end
    endcase
  end

  // A write needs the completing edge; a stray access phase changes nothing
  assign wr_go = (apb_ff == APB_ACC) && PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;

  // Control writes land only at the completing edge
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      nxt_ctrl[s] = ctrl_ff[s];
      nxt_byp[s] = byp_ff[s];
    end
    if (wr_go) begin
      if (hit(PADDR_IN, `OFF_NS_CTRL)) nxt_ctrl[`ST_NS] = PWDATA_IN[3:0];
      if (hit(PADDR_IN, `OFF_NS_BYP)) nxt_byp[`ST_NS] = PWDATA_IN[2:0];
      if (SECURE_INTERFACE_PRESENT && hit(PADDR_IN, `OFF_S_CTRL)) nxt_ctrl[`ST_S] = PWDATA_IN[3:0];
      if (SECURE_INTERFACE_PRESENT && hit(PADDR_IN, `OFF_S_BYP)) nxt_byp[`ST_S] = PWDATA_IN[2:0];
    end
  end

  // Register the bus and control state
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      apb_ff <= APB_IDLE;
      PRDATA_OUT <= `WORD_ZERO;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      // Both states come up disabled
      ctrl_ff[`ST_NS] <= `CTRL_RST;
      ctrl_ff[`ST_S] <= `CTRL_RST;
      byp_ff[`ST_NS] <= {2'b00, NS_ABORT_RST};
      byp_ff[`ST_S] <= {2'b00, S_ABORT_RST};
    end else if (CE_IN) begin
      apb_ff <= nxt_apb;
      PRDATA_OUT <= nxt_prdata;
      PREADY_OUT <= nxt_pready;
      PSLVERR_OUT <= nxt_pslverr;
      ctrl_ff <= nxt_ctrl;
      byp_ff <= nxt_byp;
    end
  end

  // ************************************
  // Transaction decision
  // ************************************
  logic sec;
  logic st;
  logic en;
  logic s2_en;
  logic s1_act;
  logic s1ns;
  logic rs_walk;
  logic rs_final;
  logic rs_base;
  rsp_t nxt_rsp;
  svc_t nxt_ns_svc;
  svc_t nxt_s_svc;
  logic nxt_rsp_valid;
  rsp_t nxt_rsp_out;

  // Stream classification; no Secure interface means all Non-secure
  assign sec = SECURE_INTERFACE_PRESENT & REQ_IN.stream_security_identifier;
  assign st = sec;
  // Each state's enable governs only its own streams
  assign en = ctrl_ff[st][`CB_EN];
  assign s2_en = REQ_IN.cfg[`CFG_S2BIT] & (sec ? SECURE_EL2_SUPPORTED_EFF : S2_IMPL);
  assign s1_act = REQ_IN.cfg[`CFG_S1BIT] & !REQ_IN.substream_skip_select
    & (REQ_IN.cfg != `CFG_S2ONLY);

  // ************************************
  // Stage 1 output and stage 2 space
  // ************************************
  // Stage 1 bypassed: entry field overrides the incoming NS
  always_comb begin
    if (s1_act) begin
      s1ns = REQ_IN.s1_out_ns;
    end else if (REQ_IN.bypass_security_select[1]) begin
      s1ns = REQ_IN.bypass_security_select[0];
    end else begin
      s1ns = REQ_IN.ns_in;
    end
  end

  s2_space_resolve u_resolve (
    .ns_in(s1ns),
    .sw_in(REQ_IN.stage2_secure_walk_attr),
    .sa_in(REQ_IN.stage2_secure_output_attr),
    .nsw_in(REQ_IN.stage2_nonsec_walk_attr),
    .nsa_in(REQ_IN.stage2_nonsec_output_attr),
    .walk_ns_out(rs_walk),
    .final_ns_out(rs_final),
    .nonsec_base_out(rs_base)
  );

  // ************************************
  // Decision per transaction
  // ************************************
  // The enable is read live, so a write landing at the same edge
  // only governs requests offered after it.
  // Decision built from the enable in force this cycle
  always_comb begin
    nxt_rsp = '0;
    nxt_rsp.walk_ns = 1'b1;
    nxt_rsp.final_ns = 1'b1;
    nxt_rsp.cd_fetch_ns = 1'b1;
    nxt_rsp.init_walk_ns = 1'b1;
    nxt_rsp.vm_tag = `VMID_ZERO;
    if (!en) begin
      // Untranslated; stream table left alone
      nxt_rsp.stream_table_read = 1'b0;
      if (byp_ff[st][`BB_ABORT]) begin
        nxt_rsp.abort = 1'b1;
      end else begin
        nxt_rsp.bypass = 1'b1;
        if (sec) begin
          nxt_rsp.final_ns = byp_ff[st][`BB_NSOVR] ? byp_ff[st][`BB_NSVAL]
            : REQ_IN.ns_in;
        end
      end
    end else begin
      nxt_rsp.translate = 1'b1;
      nxt_rsp.stream_table_read = 1'b1;
      if (!sec) begin
        // Non-secure walks and outputs always Non-secure
        nxt_rsp.walk_ns = 1'b1;
        nxt_rsp.final_ns = 1'b1;
        nxt_rsp.use_nonsec_ipa_base = 1'b1;
        nxt_rsp.vm_tag = REQ_IN.stage2_vm_tag;
      end else begin
        if (s1_act) nxt_rsp.cd_fetch_ns = 1'b0;
        if (s1_act && REQ_IN.el2_walk) begin
          nxt_rsp.init_walk_ns = REQ_IN.cd_bypass_security_select[REQ_IN.ttb_sel];
        end else begin
          nxt_rsp.init_walk_ns = 1'b0;
        end
        if (s2_en) begin
          nxt_rsp.walk_ns = rs_walk;
          nxt_rsp.final_ns = rs_final;
          nxt_rsp.use_nonsec_ipa_base = rs_base;
          nxt_rsp.vm_tag = REQ_IN.stage2_vm_tag;
          nxt_rsp.not_global_bit = s1ns;
          // Short format stage 2 is illegal here; refuse it
          nxt_rsp.abort = !REQ_IN.stage2_long_format_flag;
          nxt_rsp.translate = REQ_IN.stage2_long_format_flag;
        end else begin
          // IPA space maps straight onto the PA space
          nxt_rsp.walk_ns = 1'b0;
          nxt_rsp.final_ns = s1ns;
          nxt_rsp.use_nonsec_ipa_base = s1ns;
          nxt_rsp.vm_tag = `VMID_ZERO;
        end
      end
    end
  end

  // Secure services are dead without a Secure interface
  always_comb begin
    nxt_ns_svc = svc[`ST_NS];
    nxt_s_svc = SECURE_INTERFACE_PRESENT ? svc[`ST_S] : '0;
  end

  // ************************************
  // Output registers
  // ************************************
  // Keep the last decision between requests so idle fields never leak out
  always_comb begin
    nxt_rsp_valid = REQ_VALID_IN;
    nxt_rsp_out = REQ_VALID_IN ? nxt_rsp : RSP_OUT;
  end

  // Decision registered at acceptance, so later enables cannot touch it
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      RSP_VALID_OUT <= 1'b0;
      RSP_OUT <= '0;
      NS_SVC_OUT <= '0;
      S_SVC_OUT <= '0;
    end else if (CE_IN) begin
      RSP_VALID_OUT <= nxt_rsp_valid;
      RSP_OUT <= nxt_rsp_out;
      NS_SVC_OUT <= nxt_ns_svc;
      S_SVC_OUT <= nxt_s_svc;
    end
  end
endmodule : secure_stage2_and_enable_ctl

// file: bench/sec_ctl_assertions.sv
// Port checks of the security control block.
// Assumes a bind to the block; one clock domain.
`timescale 1ns/1ns
module sec_ctl_checker (
  input wire logic CLK_IN, // Clock
  input wire logic RST_B_IN, // Reset, active low
  input wire logic CE_IN, // Clock enable
  input wire logic PSEL_IN, // APB select
  input wire logic PENABLE_IN, // APB enable
  input wire logic PREADY_OUT, // APB ready
  input wire logic REQ_VALID_IN, // Request offered
  input wire sec_ctl_pkg::req_t REQ_IN, // Request fields
  input wire logic RSP_VALID_OUT, // Decision valid
  input wire sec_ctl_pkg::rsp_t RSP_OUT, // Decision
  input wire sec_ctl_pkg::svc_t NS_SVC_OUT // Non-secure services
);
  import sec_ctl_pkg::*;
  // ****************
  // Request copy
  // ****************
  req_t req_ff;
  req_t nxt_req;
  logic sec;
  // Keeps the cause of each decision for one cycle
  always_comb nxt_req = CE_IN ? REQ_IN : req_ff;
  always_ff @(posedge CLK_IN) req_ff <= nxt_req;
  assign sec = req_ff.stream_security_identifier;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  property p_answer;
    REQ_VALID_IN && CE_IN |=> RSP_VALID_OUT;
  endproperty
  a_answer: assert property (p_answer)
    else $error("request got no decision");
  property p_cause;
    RSP_VALID_OUT |-> $past(REQ_VALID_IN);
  endproperty
  a_cause: assert property (p_cause)
    else $error("decision without request");
  property p_kind;
    RSP_VALID_OUT |-> $onehot({RSP_OUT.abort, RSP_OUT.bypass, RSP_OUT.translate});
  endproperty
  a_kind: assert property (p_kind)
    else $error("decision kind not unique");
  property p_ns_stream;
    RSP_VALID_OUT && !sec |-> RSP_OUT.final_ns && RSP_OUT.walk_ns;
  endproperty
  a_ns_stream: assert property (p_ns_stream)
    else $error("non-secure stream left non-secure space");
  property p_no_table;
    RSP_VALID_OUT && RSP_OUT.bypass |-> !RSP_OUT.stream_table_read;
  endproperty
  a_no_table: assert property (p_no_table)
    else $error("bypass read the stream table");
  property p_vm_tag;
    RSP_VALID_OUT && sec && RSP_OUT.translate
      |-> RSP_OUT.vm_tag == (req_ff.cfg[1] ? req_ff.stage2_vm_tag : 16'h0000);
  endproperty
  a_vm_tag: assert property (p_vm_tag)
    else $error("secure tag wrong");
  property p_non_global;
    RSP_VALID_OUT && sec && RSP_OUT.translate && req_ff.cfg[1] && RSP_OUT.use_nonsec_ipa_base
      |-> RSP_OUT.not_global_bit;
  endproperty
  a_non_global: assert property (p_non_global)
    else $error("entry from non-secure space kept global");
  property p_s_walk;
    RSP_VALID_OUT && sec && RSP_OUT.translate && req_ff.cfg[1] && !RSP_OUT.use_nonsec_ipa_base
      |-> RSP_OUT.walk_ns == req_ff.stage2_secure_walk_attr;
  endproperty
  a_s_walk: assert property (p_s_walk)
    else $error("secure space walk attribute wrong");
  property p_svc;
    NS_SVC_OUT.pri_ok || NS_SVC_OUT.evt_new_ok |-> NS_SVC_OUT.xlat_op_ok;
  endproperty
  a_svc: assert property (p_svc)
    else $error("service allowed while disabled");
  property p_ready;
    PSEL_IN && !PENABLE_IN && CE_IN |=> PREADY_OUT ##1 !PREADY_OUT;
  endproperty
  a_ready: assert property (p_ready)
    else $error("register access not answered");
endmodule : sec_ctl_checker
bind secure_stage2_and_enable_ctl sec_ctl_checker sec_ctl_checker_inst (.CLK_IN, .RST_B_IN,
  .CE_IN, .PSEL_IN, .PENABLE_IN, .PREADY_OUT, .REQ_VALID_IN, .REQ_IN, .RSP_VALID_OUT,
  .RSP_OUT, .NS_SVC_OUT);

// file: bench/client_model.sv
// Client device that offers transactions to the block.
// Assumes the bench calls send; no backpressure exists.
`timescale 1ns/1ns
module client_model (
  input wire logic clk_in, // Bench clock
  output logic valid_out, // Request offered
  output sec_ctl_pkg::req_t req_out // Request fields
);
  import sec_ctl_pkg::*;
  // ****************
  // Request driver
  // ****************
  initial begin
    valid_out = 1'b0;
    req_out = '0;
  end
  // One request for one edge; gap makes a slow client
  task automatic send(input req_t r, input int gap);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    valid_out <= 1'b1;
    req_out <= r;
    @(posedge clk_in);
    valid_out <= 1'b0;
    req_out <= ~r; // Stale fields must not look valid
  endtask : send
endmodule : client_model

// file: bench/tb_secure_stage2_and_enable_ctl.sv
// Self-checking bench of the security control block.
// Assumes the checker bind and the client model.
`timescale 1ns/1ns
`include "sec_ctl_defines.svh"
module tb_secure_stage2_and_enable_ctl;
  import sec_ctl_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic perr;
  logic rv;
  req_t rq;
  logic rspv;
  rsp_t rsp;
  logic [31:0] rd;
  logic err;
  logic ce = 1'b1;
  svc_t ns_svc;
  svc_t s_svc;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  // ****************
  // Clock, parts
  // ****************
  always #50 clk = ~clk;
  secure_stage2_and_enable_ctl secure_stage2_and_enable_ctl_inst (.CLK_IN(clk),
    .RST_B_IN(rst_b), .CE_IN(ce), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(perr), .REQ_VALID_IN(rv), .REQ_IN(rq), .RSP_VALID_OUT(rspv),
    .RSP_OUT(rsp), .NS_SVC_OUT(ns_svc), .S_SVC_OUT(s_svc));
  client_model client_model_inst (.clk_in(clk), .valid_out(rv), .req_out(rq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  // APB transfer held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Only the bench's hang guard ends a wait that never sees ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  function automatic logic [4:0] pk(input rsp_t r);
    return {r.abort, r.bypass, r.translate, r.final_ns, r.stream_table_read};
  endfunction : pk
  task automatic go(input req_t r);
    client_model_inst.send(r, 1);
    @(negedge clk);
    check(32'(rspv), 32'h1);
  endtask : go
  task automatic t_regs;
    apb(1'b0, `OFF_ID, 32'h0);
    check(rd, 32'h3);
    apb(1'b0, `OFF_S_BYP, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, `OFF_NS_CTRL, 32'hE);
    apb(1'b0, `OFF_NS_CTRL, 32'h0);
    check(rd, 32'hE);
    apb(1'b0, `OFF_STAT, 32'h0);
    check(rd, 32'h28);
    check(32'({s_svc, ns_svc}), 32'h028);
    apb(1'b0, 8'h18, 32'h0);
    check(32'(err), 32'h1);
  endtask : t_regs
  task automatic t_bypass;
    req_t r;
    r = '0;
    go(r);
    check(32'(pk(rsp)), 32'hA);
    r.stream_security_identifier = 1'b1;
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, `OFF_S_BYP, 32'(2 + 4 * j));
      r.ns_in = (j == 0);
      go(r);
      check(32'(pk(rsp)), 32'(8 + 2 * j));
    end
    apb(1'b1, `OFF_NS_BYP, 32'h1);
    go(r);
    check(32'(pk(rsp)), 32'hA);
    r.stream_security_identifier = 1'b0;
    go(r);
    check(32'(pk(rsp) & 5'h1D), 32'h10);
    apb(1'b1, `OFF_NS_BYP, 32'h0);
  endtask : t_bypass
  task automatic t_enable;
    req_t r;
    logic [4:0] v;
    logic w;
    logic f;
    r = '0;
    r.cfg = 3'h7;
    apb(1'b1, `OFF_NS_CTRL, 32'h1);
    go(r);
    check(32'({pk(rsp), rsp.walk_ns}), 32'hF);
    r.stream_security_identifier = 1'b1;
    go(r);
    check(32'(pk(rsp)), 32'hA);
    apb(1'b1, `OFF_S_CTRL, 32'h5);
    apb(1'b0, `OFF_STAT, 32'h0);
    check(rd, 32'h1B03);
    check(32'({s_svc, ns_svc}), 32'h6C3);
    r.cfg = `CFG_S2ONLY;
    r.stage2_long_format_flag = 1'b1;
    r.bypass_security_select = 2'h2;
    for (int i = 0; i < 32; i++) begin
      v = 5'(i);
      {r.bypass_security_select[0], r.stage2_secure_walk_attr} = v[4:3];
      {r.stage2_secure_output_attr, r.stage2_nonsec_walk_attr} = v[2:1];
      r.stage2_nonsec_output_attr = v[0];
      r.stage2_vm_tag = {8'hA5, 3'h0, v};
      go(r);
      w = v[4] ? v[1] : v[3];
      f = v[4] ? (v[3] | v[1] | v[0]) : (v[3] | v[2]);
      check(32'(pk(rsp)), 32'({3'h1, f, 1'b1}));
      check(32'({rsp.walk_ns, rsp.use_nonsec_ipa_base, rsp.vm_tag}),
        32'({w, v[4], r.stage2_vm_tag}));
      check(32'(rsp.not_global_bit | !v[4]), 32'h1);
    end
    r.cfg = 3'h5;
    r.el2_walk = 1'b1;
    r.cd_bypass_security_select = 2'h2;
    for (int j = 0; j < 2; j++) begin
      r.ttb_sel = (j == 1);
      r.s1_out_ns = (j == 1);
      go(r);
      check(32'(pk(rsp)), 32'(5 + 2 * j));
      check(32'({rsp.cd_fetch_ns, rsp.init_walk_ns, rsp.vm_tag}), 32'(j << 16));
    end
  endtask : t_enable
  // Clock enable low: an offered request must get no decision
  task automatic t_freeze;
    req_t r;
    r = '0;
    @(posedge clk);
    ce <= 1'b0;
    client_model_inst.send(r, 0);
    @(negedge clk);
    check(32'(rspv), 32'h0);
    @(posedge clk);
    ce <= 1'b1;
  endtask : t_freeze
  // Main sequence after the reset hold
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_bypass;
    t_enable;
    t_freeze;
    tally_and_finish;
  end
endmodule : tb_secure_stage2_and_enable_ctl
